// File: hw/dacw_pkg.sv
// Shared constants and types for the dual DAC serial write front end
package dacw_pkg;
    // Core clock period and derived probe timing
    localparam int REF_PERIOD_NS = 5;
    localparam int PROBE_NS = 100;
    localparam logic [4:0] PROBE_CYC =
        5'((PROBE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    // Least wait from end of the last acked byte to an update edge
    localparam int T1_NS = 400;
    localparam int T1_CYC = (T1_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

    // Serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] DATA_BYTES = 2'h3;
    localparam int WORD_W = 24;
    localparam logic [6:0] ADDR_GLOBAL = 7'h73;
    localparam logic [2:0] ADDR_HI_BASE = 3'h1;

    // Reset values
    localparam logic [23:0] DAC_RESET_CODE = 24'h000000;
    localparam logic [1:0] PD_RESET = 2'h0;

    // Three-state pin readings
    localparam logic [1:0] TRIT_GND = 2'h0;
    localparam logic [1:0] TRIT_FLOAT = 2'h1;
    localparam logic [1:0] TRIT_VCC = 2'h2;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_ADDR = 3'b001,
        LK_ACK_A = 3'b010,
        LK_DATA = 3'b011,
        LK_ACK_D = 3'b100,
        LK_IGNORE = 3'b101
    } dacw_link_e;

    typedef enum logic [1:0] {
        PR_HI = 2'b00,
        PR_LO = 2'b01,
        PR_DONE = 2'b10
    } dacw_probe_e;
endpackage : dacw_pkg

// File: hw/dacw_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module dacw_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : dacw_sync
`default_nettype wire

// File: hw/dacw_addr_map.sv
// Maps three pin readings onto the 7-bit target address
`timescale 1ns/100ps
`default_nettype none
module dacw_addr_map (
    input wire logic [5:0] trits_i,
    output logic [6:0] addr_o
);
    // Index is pin2*9 + pin1*3 + pin0; four addresses per high group
    function automatic logic [6:0] trit_addr(input logic [5:0] t);
        logic [4:0] n;
        n = 5'(t[5:4] * 9) + 5'(t[3:2] * 3) + 5'(t[1:0]);
        trit_addr = {n[4:2] + dacw_pkg::ADDR_HI_BASE, 2'h0, n[1:0]};
    endfunction : trit_addr

    assign addr_o = trit_addr(trits_i);
endmodule : dacw_addr_map
`default_nettype wire

// File: hw/dacw_top.sv
// Serial write target, address probe and update control of the dual DAC
`timescale 1ns/100ps
`default_nettype none
module dacw_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic async_update_n_i,
    input wire logic [1:0] pwr_down_req_i,
    input wire logic addr_select_0_i,
    input wire logic addr_select_1_i,
    input wire logic addr_select_2_i,
    output logic addr_select_0_o,
    output logic addr_select_1_o,
    output logic addr_select_2_o,
    output logic addr_select_0_oe_o,
    output logic addr_select_1_oe_o,
    output logic addr_select_2_oe_o,
    output logic [23:0] input_code_o,
    output logic [23:0] dac_code_o,
    output logic word_pending_o,
    output logic [1:0] channel_on_o,
    output logic addr_ready_o
);
    // ---------------- Core domain: address probe ----------------
    logic [2:0] sel_s;
    logic [2:0] sel_hi_reg;
    logic [2:0] sel_lo_reg;
    logic [2:0] sel_drive_reg;
    logic [2:0] sel_oe_reg;
    logic [4:0] probe_cnt_reg;
    dacw_pkg::dacw_probe_e probe_reg;
    logic [5:0] trits;
    logic [6:0] own_addr;

    dacw_sync #(.W(3)) u_sel_sync (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i({addr_select_2_i, addr_select_1_i, addr_select_0_i}),
        .q_o(sel_s)
    );

    // Drive each pin high then low; a pin that follows both is floating.
    // The pad drive is weak, so a tied pin keeps its own level.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            probe_reg <= dacw_pkg::PR_HI;
            probe_cnt_reg <= 5'h00;
            sel_hi_reg <= 3'h0;
            sel_lo_reg <= 3'h0;
        end else begin
            case (probe_reg)
                dacw_pkg::PR_HI: begin
                    probe_cnt_reg <= probe_cnt_reg + 5'h01;
                    if (probe_cnt_reg == dacw_pkg::PROBE_CYC) begin
                        sel_hi_reg <= sel_s;
                        probe_cnt_reg <= 5'h00;
                        probe_reg <= dacw_pkg::PR_LO;
                    end
                end
                dacw_pkg::PR_LO: begin
                    probe_cnt_reg <= probe_cnt_reg + 5'h01;
                    if (probe_cnt_reg == dacw_pkg::PROBE_CYC) begin
                        sel_lo_reg <= sel_s;
                        probe_reg <= dacw_pkg::PR_DONE;
                    end
                end
                default: probe_reg <= dacw_pkg::PR_DONE;
            endcase
        end
    end

    // Pin drive follows the probe phase; released once done
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sel_drive_reg <= 3'h7;
            sel_oe_reg <= 3'h7;
        end else begin
            sel_drive_reg <= (probe_reg == dacw_pkg::PR_HI) ? 3'h7 : 3'h0;
            sel_oe_reg <= (probe_reg == dacw_pkg::PR_DONE) ? 3'h0 : 3'h7;
        end
    end

    // Classify each pin from its two readings
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_trit
            assign trits[2*gi+1:2*gi] =
                (sel_hi_reg[gi] && sel_lo_reg[gi]) ? dacw_pkg::TRIT_VCC :
                (!sel_hi_reg[gi] && !sel_lo_reg[gi]) ? dacw_pkg::TRIT_GND :
                dacw_pkg::TRIT_FLOAT;
        end
    endgenerate

    dacw_addr_map u_addr_map (
        .trits_i(trits),
        .addr_o(own_addr)
    );

    assign {addr_select_2_o, addr_select_1_o, addr_select_0_o} = sel_drive_reg;
    assign {addr_select_2_oe_o, addr_select_1_oe_o, addr_select_0_oe_o} =
        sel_oe_reg;
    assign addr_ready_o = (probe_reg == dacw_pkg::PR_DONE);

    // ---------------- Link domain ----------------
    logic rst_link;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic addr_ok_s;
    logic ack_s;
    dacw_pkg::dacw_link_e link_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [7:0] shift_reg;
    logic [23:0] data_reg;
    logic [23:0] word_hold_reg;
    logic req_tgl_reg;
    logic sda_oe_reg;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic addr_hit;
    logic byte_end;
    logic ack_tgl_reg;

    dacw_sync #(.W(1)) u_rst_sync (
        .clk_i(link_clk_i),
        .rst_i(1'b0),
        .d_i(rst_i),
        .q_o(rst_link)
    );

    // Address is static after probing, so only its ready level is synced
    // Runs through reset so the pin copies match the idle levels when
    // reset ends; a zeroed copy would fake clock and data edges there
    dacw_sync #(.W(4)) u_link_sync (
        .clk_i(link_clk_i),
        .rst_i(1'b0),
        .d_i({scl_i, sda_i, addr_ready_o, ack_tgl_reg}),
        .q_o({scl_s, sda_s, addr_ok_s, ack_s})
    );

    // Delayed copies for edge and bus condition detection
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign byte_end = scl_fall && (bit_cnt_reg == dacw_pkg::BITS_PER_BYTE);
    assign addr_hit = addr_ok_s && !shift_reg[0] &&
        ((shift_reg[7:1] == own_addr) ||
         (shift_reg[7:1] == dacw_pkg::ADDR_GLOBAL));

    // Transfer sequencer; a start always restarts address reception
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            link_reg <= dacw_pkg::LK_IDLE;
            bit_cnt_reg <= 4'h0;
            byte_cnt_reg <= 2'h0;
            shift_reg <= 8'h00;
            data_reg <= 24'h000000;
            sda_oe_reg <= 1'b0;
        end else if (bus_start) begin
            link_reg <= dacw_pkg::LK_ADDR;
            bit_cnt_reg <= 4'h0;
            byte_cnt_reg <= 2'h0;
            sda_oe_reg <= 1'b0;
        end else if (bus_stop) begin
            link_reg <= dacw_pkg::LK_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            if ((link_reg == dacw_pkg::LK_ADDR ||
                 link_reg == dacw_pkg::LK_DATA) && scl_rise) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            case (link_reg)
                dacw_pkg::LK_ADDR: begin
                    if (byte_end) begin
                        bit_cnt_reg <= 4'h0;
                        if (addr_hit) begin
                            link_reg <= dacw_pkg::LK_ACK_A;
                            sda_oe_reg <= 1'b1;
                        end else begin
                            link_reg <= dacw_pkg::LK_IGNORE;
                        end
                    end
                end
                dacw_pkg::LK_DATA: begin
                    if (byte_end) begin
                        bit_cnt_reg <= 4'h0;
                        data_reg <= {data_reg[15:0], shift_reg};
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                        link_reg <= dacw_pkg::LK_ACK_D;
                        sda_oe_reg <= 1'b1;
                    end
                end
                dacw_pkg::LK_ACK_A: begin
                    if (scl_fall) begin
                        link_reg <= dacw_pkg::LK_DATA;
                        sda_oe_reg <= 1'b0;
                    end
                end
                dacw_pkg::LK_ACK_D: begin
                    if (scl_fall) begin
                        sda_oe_reg <= 1'b0;
                        // Bytes past the word are left unacknowledged
                        link_reg <= (byte_cnt_reg == dacw_pkg::DATA_BYTES) ?
                            dacw_pkg::LK_IGNORE : dacw_pkg::LK_DATA;
                    end
                end
                default: sda_oe_reg <= 1'b0;
            endcase
        end
    end

    // Hand a finished word over; a word arriving while the core has not
    // yet taken the previous one is dropped, which needs sub-us spacing
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            word_hold_reg <= 24'h000000;
            req_tgl_reg <= 1'b0;
        end else if (link_reg == dacw_pkg::LK_ACK_D && scl_fall &&
                     byte_cnt_reg == dacw_pkg::DATA_BYTES &&
                     req_tgl_reg == ack_s) begin
            word_hold_reg <= data_reg;
            req_tgl_reg <= !req_tgl_reg;
        end
    end

    assign sda_o = 1'b0; // Open drain: only ever pulls low
    assign sda_oe_o = sda_oe_reg;

    // ---------------- Core domain: word and update ----------------
    logic req_s;
    logic upd_s;
    logic upd_d_reg;
    logic [23:0] input_reg;
    logic [23:0] dac_reg;
    logic ready_reg;
    logic [1:0] pd_reg;
    logic word_take;
    logic upd_fall;

    // Not reset: a zeroed update copy would fake a fall and a wake-up
    dacw_sync #(.W(2)) u_core_sync (
        .clk_i(ref_clk_i),
        .rst_i(1'b0),
        .d_i({req_tgl_reg, async_update_n_i}),
        .q_o({req_s, upd_s})
    );

    // Delayed copies; ack toggle mirrors the request once taken
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_tgl_reg <= 1'b0;
            upd_d_reg <= 1'b1;
        end else begin
            ack_tgl_reg <= req_s;
            upd_d_reg <= upd_s;
        end
    end

    assign word_take = req_s != ack_tgl_reg;
    // Handover latency is far below the master's wait, so the word is
    // already pending when the update edge is allowed to come
    assign upd_fall = upd_d_reg && !upd_s;

    // Input register and pending flag; a new word beats the clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            input_reg <= dacw_pkg::DAC_RESET_CODE;
            ready_reg <= 1'b0;
        end else if (word_take) begin
            input_reg <= word_hold_reg;
            ready_reg <= 1'b1;
        end else if (upd_fall) begin
            ready_reg <= 1'b0;
        end
    end

    // DAC register moves only on a falling edge with a word pending
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dac_reg <= dacw_pkg::DAC_RESET_CODE;
        end else if (upd_fall && ready_reg) begin
            dac_reg <= input_reg;
        end
    end

    // Low update level wakes and pins channels on; high leaves software
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pd_reg <= dacw_pkg::PD_RESET;
        end else if (!upd_s) begin
            pd_reg <= 2'h0;
        end else begin
            pd_reg <= pd_reg | pwr_down_req_i;
        end
    end

    assign input_code_o = input_reg;
    assign dac_code_o = dac_reg;
    assign word_pending_o = ready_reg;
    assign channel_on_o = ~pd_reg;

    // ---------------- Checks ----------------
    sequence seq_armed_fall;
        ready_reg && upd_fall;
    endsequence

    chk_update_copy: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        seq_armed_fall |=> (dac_reg == $past(input_reg)) && !ready_reg)
        else $error("update edge did not copy input");
    chk_no_word_hold: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (!upd_s && !ready_reg && !word_take) |=> $stable(dac_reg)
            && (pd_reg == 2'h0))
        else $error("update without word changed dac or left sleep");
    chk_low_powered: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (!upd_s) [*2] |-> channel_on_o == 2'h3)
        else $error("channel off while update held low");
    chk_high_idle: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (upd_s && upd_d_reg) |=> $stable(dac_reg))
        else $error("dac changed with update held high");
    chk_sample_rise: assert property (
        @(posedge link_clk_i) disable iff (rst_link)
        (link_reg == dacw_pkg::LK_DATA && scl_rise && !bus_start
            && !bus_stop) |=> shift_reg[0] == $past(sda_s))
        else $error("bit not taken on clock rise");
    chk_release_shift: assert property (
        @(posedge link_clk_i) disable iff (rst_link)
        (link_reg == dacw_pkg::LK_ADDR || link_reg == dacw_pkg::LK_DATA)
            |-> !sda_oe_reg)
        else $error("data line driven while shifting");
    chk_probe_drive: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(probe_reg == dacw_pkg::PR_LO) |=> (sel_drive_reg == 3'h0)
            && (sel_oe_reg == 3'h7))
        else $error("probe low phase not driven");
    chk_read_nack: assert property (
        @(posedge link_clk_i) disable iff (rst_link)
        (link_reg == dacw_pkg::LK_ADDR && byte_end && shift_reg[0]
            && !bus_start && !bus_stop)
            |=> (link_reg == dacw_pkg::LK_IGNORE) && !sda_oe_reg)
        else $error("read request acknowledged");
    chk_addr_map: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        addr_ready_o |-> (own_addr[3:2] == 2'h0) && (own_addr[6:4] != 3'h0)
            && (own_addr != dacw_pkg::ADDR_GLOBAL))
        else $error("pin address outside its table");
    chk_global_ack: assert property (
        @(posedge link_clk_i) disable iff (rst_link)
        (link_reg == dacw_pkg::LK_ADDR && byte_end && addr_ok_s
            && shift_reg == {dacw_pkg::ADDR_GLOBAL, 1'b0}
            && !bus_start && !bus_stop) |=> sda_oe_reg)
        else $error("global address not acknowledged");
    chk_ignore_release: assert property (
        @(posedge link_clk_i) disable iff (rst_link)
        (link_reg == dacw_pkg::LK_IGNORE || link_reg == dacw_pkg::LK_IDLE)
            |-> !sda_oe_reg)
        else $error("line driven while ignoring");
endmodule : dacw_top
`default_nettype wire

// File: test/dacw_i2c_master.sv
// Bit-banging two-wire bus master that plays the far side of the link
`timescale 1ns/100ps
`default_nettype none
module dacw_i2c_master #(
    parameter int HALF_CYC = 40
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    // Both lines released at start, pull-ups hold them high
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // Half a bus clock; far slower than the link sampler needs
    task automatic half_wait();
        repeat (HALF_CYC) @(posedge clk_i);
    endtask : half_wait

    // START: data falls while the clock is high
    task automatic start();
        sda_low_o <= 1'b1;
        half_wait();
        scl_low_o <= 1'b1;
        half_wait();
    endtask : start

    // STOP: data rises while the clock is high
    task automatic stop();
        sda_low_o <= 1'b1;
        half_wait();
        scl_low_o <= 1'b0;
        half_wait();
        sda_low_o <= 1'b0;
        half_wait();
    endtask : stop

    // One clock pulse, wire sampled mid-high where it is stable
    task automatic pulse(output logic lvl);
        scl_low_o <= 1'b0;
        repeat (HALF_CYC / 2) @(posedge clk_i);
        lvl = sda_i;
        repeat (HALF_CYC / 2) @(posedge clk_i);
        scl_low_o <= 1'b1;
    endtask : pulse

    // Byte MSB first, data only moves while the clock is low
    task automatic send_byte(input logic [7:0] b, output logic ack,
                             output logic clash);
        logic lvl;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sda_low_o <= ~b[i];
            half_wait();
            pulse(lvl);
            if (b[i] && lvl !== 1'b1) clash = 1'b1;
            half_wait();
        end
        // Released for the answer; a low wire is the acknowledge
        sda_low_o <= 1'b0;
        half_wait();
        pulse(lvl);
        ack = (lvl === 1'b0);
        half_wait();
    endtask : send_byte
endmodule : dacw_i2c_master
`default_nettype wire

// File: test/tb_dual_dac_serial_write_and_async_update.sv
// Self-checking bench for the dual DAC serial write front end
`timescale 1ns/100ps
`default_nettype none
module tb_dual_dac_serial_write_and_async_update;
    logic ref_clk, link_clk, rst, upd_n, scl_low, sda_low;
    logic sda_o, sda_oe, pend, ready;
    logic [1:0] pd_req, ch_on;
    logic [2:0] ca_o, ca_oe, ca_lvl;
    logic [23:0] in_code, dac_code;
    wire scl_w = ~scl_low;
    wire sda_w = ~(sda_low | (sda_oe & ~sda_o));
    int error_cnt = 0;
    int cmp_count = 0;

    // Pins: select 0 tied to supply, 1 floating, 2 tied to ground
    assign ca_lvl[0] = 1'b1;
    assign ca_lvl[1] = ca_oe[1] ? ca_o[1] : 1'b0;
    assign ca_lvl[2] = 1'b0;

    // Core and link clocks with unrelated phase
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    dacw_top dut (
        .ref_clk_i(ref_clk), .rst_i(rst), .link_clk_i(link_clk),
        .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .async_update_n_i(upd_n), .pwr_down_req_i(pd_req),
        .addr_select_0_i(ca_lvl[0]), .addr_select_1_i(ca_lvl[1]),
        .addr_select_2_i(ca_lvl[2]), .addr_select_0_o(ca_o[0]),
        .addr_select_1_o(ca_o[1]), .addr_select_2_o(ca_o[2]),
        .addr_select_0_oe_o(ca_oe[0]), .addr_select_1_oe_o(ca_oe[1]),
        .addr_select_2_oe_o(ca_oe[2]), .input_code_o(in_code),
        .dac_code_o(dac_code), .word_pending_o(pend),
        .channel_on_o(ch_on), .addr_ready_o(ready)
    );

    dacw_i2c_master master (
        .clk_i(ref_clk), .sda_i(sda_w),
        .scl_low_o(scl_low), .sda_low_o(sda_low)
    );

    task automatic complete_run();
        $display("errors %0d, comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk_code(string what, logic [23:0] exp, logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_code

    task automatic chk_bits(string what, logic [1:0] exp, logic [1:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bits

    task automatic wait_cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cyc

    // Whole frame: address byte then data bytes, acks judged on the wire
    task automatic send_frame(logic [7:0] addr_b, logic [23:0] word,
                              int nbytes, logic exp_ack);
        logic ack, clash;
        master.start();
        master.send_byte(addr_b, ack, clash);
        chk_bits("address ack", {1'b0, exp_ack}, {1'b0, ack});
        chk_bits("address clash", 2'h0, {1'b0, clash});
        for (int i = 0; i < nbytes; i++) begin
            master.send_byte(word[23 - 8 * i -: 8], ack, clash);
            chk_bits("data ack", {1'b0, exp_ack}, {1'b0, ack});
            chk_bits("data clash", 2'h0, {1'b0, clash});
        end
        master.stop();
    endtask : send_frame

    // Falling update edge after a full word, then release the pin
    task automatic pulse_update(logic [23:0] exp_dac);
        wait_cyc(dacw_pkg::T1_CYC);
        upd_n <= 1'b0;
        wait_cyc(8);
        chk_code("dac after update", exp_dac, dac_code);
        chk_bits("pending after update", 2'h0, {1'b0, pend});
        upd_n <= 1'b1;
        wait_cyc(8);
    endtask : pulse_update

    // Reset values, then the address probe must finish in bounded time
    task automatic t_reset();
        chk_code("dac reset", dacw_pkg::DAC_RESET_CODE, dac_code);
        chk_bits("channels reset", 2'h3, ch_on);
        chk_bits("pending reset", 2'h0, {1'b0, pend});
        chk_bits("sda drive reset", 2'h0, {1'b0, sda_oe});
        for (int i = 0; i < 200 && ready !== 1'b1; i++) wait_cyc(1);
        chk_bits("probe ready", 2'h1, {1'b0, ready});
        wait_cyc(30);
    endtask : t_reset

    // Pin address 0x21 (ground, float, supply); word waits for the pin
    task automatic t_pin_addr_write();
        send_frame(8'h42, 24'ha53c96, 3, 1'b1);
        chk_code("input word", 24'ha53c96, in_code);
        chk_bits("pending set", 2'h1, {1'b0, pend});
        chk_code("dac held", 24'h000000, dac_code);
        pulse_update(24'ha53c96);
    endtask : t_pin_addr_write

    // Global address reaches the device regardless of the pins
    task automatic t_global_write();
        send_frame(8'he6, 24'h123456, 3, 1'b1);
        chk_code("global word", 24'h123456, in_code);
        pulse_update(24'h123456);
    endtask : t_global_write

    // Foreign address and a read request are both left unanswered
    task automatic t_refused();
        send_frame(8'h44, 24'hffffff, 3, 1'b0);
        send_frame(8'h43, 24'h000000, 0, 1'b0);
        chk_code("word kept", 24'h123456, in_code);
        chk_bits("no pending", 2'h0, {1'b0, pend});
    endtask : t_refused

    // Power-down with pin high, short frame, then pin low wakes only
    task automatic t_wake_partial();
        pd_req <= 2'h3;
        wait_cyc(1);
        pd_req <= 2'h0;
        wait_cyc(8);
        chk_bits("powered down", 2'h0, ch_on);
        send_frame(8'h42, 24'habcdef, 2, 1'b1);
        chk_bits("short frame", 2'h0, {1'b0, pend});
        wait_cyc(dacw_pkg::T1_CYC);
        upd_n <= 1'b0;
        wait_cyc(8);
        chk_bits("woken", 2'h3, ch_on);
        chk_code("dac unchanged", 24'h123456, dac_code);
        pd_req <= 2'h3;
        wait_cyc(8);
        chk_bits("power-down ignored", 2'h3, ch_on);
        pd_req <= 2'h0;
        upd_n <= 1'b1;
        wait_cyc(8);
        chk_bits("still on", 2'h3, ch_on);
    endtask : t_wake_partial

    // Main sequence
    initial begin
        rst = 1'b1;
        upd_n = 1'b1;
        pd_req = 2'h0;
        wait_cyc(12);
        rst <= 1'b0;
        wait_cyc(1);
        t_reset();
        t_pin_addr_write();
        t_global_write();
        t_refused();
        t_wake_partial();
        complete_run();
    end

    // Watchdog well beyond the expected run of about 20000 cycles
    initial begin
        wait_cyc(100000);
        error_cnt++;
        complete_run();
    end
endmodule : tb_dual_dac_serial_write_and_async_update
`default_nettype wire
